// ===== rtl/blk_crc_chk.sv
/*
  Approach data block remainder generator and checker with field decode.
  Holds a register port, the serial bit stream in and out, and the decoded field outputs.
  Assumes the loader presents one bit per in_valid cycle after a start, in transmission order.
*/
//
// Behaviour
// - Divide by the 33-term generator, normal form 0x814141ab.
// - Check value is 32 bits; one full remainder per block.
// - Message bits form one word in transmission order, no byte reversal.
// - Bits are numbered from the operation type LSB upward through every field.
// - Check bits follow the message, highest remainder coefficient first.
// - Message times x^32, divided by generator; remainder is the check value.
// - Generating emits unaltered message bits then the remainder bits.
// - Checking compares all 32 bits; usable only on exact match, else error flag.
// - All division arithmetic is exclusive-OR without carries.
// - Block bits are passed through and checked exactly as received.
// - Runway number zero forces a 38 m course width.
// - Vertical alert limit zero flags lateral-only, vertical outputs unusable.
// - Division covers every field through the vertical alert limit.
`timescale 1ns/10ps
module blk_crc_chk
  import blk_crc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic block_start,
  input wire logic in_valid,
  input wire logic in_bit,
  output logic out_valid,
  output logic out_bit,
  output logic busy,
  output logic block_done,
  output logic block_ok,
  output logic crc_error,
  output logic lateral_only,
  output logic vertical_usable,
  output logic [QM_W-1:0] course_width_qm,
  output logic irq
);

  typedef struct packed {
    state_t st;
    logic [CNT_W-1:0] cnt;
    logic [CRC_W-1:0] crc;
    logic [CRC_W-1:0] sh;
    logic gen_cfg;
    logic gen;
    logic [5:0] rwy;
    logic [7:0] cw;
    logic [7:0] vlim;
    logic done;
    logic ok;
    logic err;
    logic lat;
    logic vert;
    logic [QM_W-1:0] cw_qm;
    logic [IRQ_W-1:0] ist;
    logic [IRQ_W-1:0] imask;
    logic irq;
    logic busy;
    logic ov;
    logic ob;
    logic [31:0] rdat;
  } regs_t;

  regs_t r_q;
  regs_t r_d;
  logic [CRC_W-1:0] crc_nx;

  // Field windows follow the bit count, so gaps in the stream never shift a field.
  function automatic logic in_field(input logic [CNT_W-1:0] c, input logic [CNT_W-1:0] lsb,
                                    input logic [CNT_W-1:0] w);
    in_field = (c >= lsb) && (c < CNT_W'(lsb + w));
  endfunction : in_field

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] k);
    hit = (a == k);
  endfunction : hit

  crc_step u_step (
    .crc(r_q.crc),
    .bit_in(in_bit),
    .crc_next(crc_nx)
  );

  always_comb
  begin
    logic start;
    logic last;
    logic [IRQ_W-1:0] ev;
    start = 1'b0;
    last = 1'b0;
    ev = '0;
    r_d = r_q;
    r_d.ov = 1'b0;
    r_d.ob = 1'b0;
    // Read data stand one cycle and fall back to zero, so a stale word never looks like an answer.
    r_d.rdat = '0;

    if (wr && hit(addr, ADDR_CTRL))
    begin
      r_d.gen_cfg = wdata[CTRL_GEN];
      start = wdata[CTRL_START];
    end
    if (wr && hit(addr, ADDR_IRQ_MASK))
    begin
      r_d.imask = wdata[IRQ_W-1:0];
    end
    if (block_start)
    begin
      start = 1'b1;
    end

    unique case (r_q.st)
      ST_IDLE:
      begin
        // Bits offered while idle are dropped; only busy tells the loader so.
      end
      ST_MSG:
      begin
        if (in_valid)
        begin
          // Every message bit, operation type LSB first, enters the division.
          r_d.crc = crc_nx;
          r_d.cnt = CNT_W'(r_q.cnt + 1'b1);
          // Message bits leave unaltered in both modes.
          r_d.ov = 1'b1;
          r_d.ob = in_bit;
          // Fields arrive LSB first, so they shift in from the top.
          if (in_field(r_q.cnt, RWY_LSB, RWY_W))
          begin
            r_d.rwy = {in_bit, r_q.rwy[5:1]};
          end
          if (in_field(r_q.cnt, CW_LSB, CW_W))
          begin
            r_d.cw = {in_bit, r_q.cw[7:1]};
          end
          if (in_field(r_q.cnt, VAL_LSB, VAL_W))
          begin
            r_d.vlim = {in_bit, r_q.vlim[7:1]};
          end
          if (r_d.cnt == MSG_BITS)
          begin
            // Heliport blocks ignore the coded width.
            r_d.cw_qm = (r_d.rwy == RWY_HELI) ? CW_HELI_QM : QM_W'(CW_BASE_QM + QM_W'(r_d.cw));
            // A zero alert limit leaves lateral guidance only.
            r_d.lat = (r_d.vlim == VAL_LATERAL);
            r_d.vert = (r_d.vlim != VAL_LATERAL);
            if (r_q.gen)
            begin
              // The emitter walks a copy so the result register keeps the remainder.
              r_d.sh = crc_nx;
              r_d.st = ST_EMIT;
            end
            else
            begin
              r_d.st = ST_CHK;
            end
          end
        end
      end
      ST_CHK:
      begin
        if (in_valid)
        begin
          // Check bits do not enter the division; they shift into the compare register and echo on the output.
          // Received check bits come highest coefficient first.
          r_d.sh = {r_q.sh[CRC_W-2:0], in_bit};
          r_d.cnt = CNT_W'(r_q.cnt + 1'b1);
          r_d.ov = 1'b1;
          r_d.ob = in_bit;
          if (r_d.cnt == BLK_BITS)
          begin
            last = 1'b1;
            // All 32 bits must agree before the block is declared usable.
            r_d.ok = (r_d.sh == r_q.crc);
            r_d.err = (r_d.sh != r_q.crc);
            ev[IRQ_ERR] = (r_d.sh != r_q.crc);
          end
        end
      end
      ST_EMIT:
      begin
        // Bits offered on the stream now are ignored, so the loader must wait for done.
        // Remainder bits follow the message at once, top coefficient first.
        r_d.ov = 1'b1;
        r_d.ob = r_q.sh[CRC_W-1];
        r_d.sh = {r_q.sh[CRC_W-2:0], 1'b0};
        r_d.cnt = CNT_W'(r_q.cnt + 1'b1);
        if (r_d.cnt == BLK_BITS)
        begin
          last = 1'b1;
          r_d.ok = 1'b1;
        end
      end
    endcase

    if (last)
    begin
      r_d.st = ST_IDLE;
      r_d.done = 1'b1;
      ev[IRQ_DONE] = 1'b1;
    end

    // A start wins over any block in flight and restarts the division from zero.
    // A start during emission drops the rest of the remainder; the loader waits for done.
    if (start)
    begin
      r_d.st = ST_MSG;
      r_d.cnt = '0;
      r_d.crc = CRC_INIT;
      r_d.sh = '0;
      r_d.gen = r_d.gen_cfg;
      r_d.done = 1'b0;
      r_d.ok = 1'b0;
      r_d.err = 1'b0;
      r_d.lat = 1'b0;
      r_d.vert = 1'b0;
    end

    // A new event survives a clear written in the same cycle.
    if (wr && hit(addr, ADDR_IRQ_STAT))
    begin
      r_d.ist = r_q.ist & ~wdata[IRQ_W-1:0];
    end
    r_d.ist = r_d.ist | ev;
    r_d.irq = |(r_d.ist & r_d.imask);
    // Busy is a flop of its own so that the port never shows a decode glitch.
    r_d.busy = (r_d.st != ST_IDLE);

    if (rd)
    begin
      if (hit(addr, ADDR_CTRL))
      begin
        r_d.rdat = 32'(r_q.gen_cfg);
      end
      else if (hit(addr, ADDR_STATUS))
      begin
        r_d.rdat = {26'h0, r_q.vert, r_q.lat, r_q.err, r_q.ok, r_q.done, r_q.st != ST_IDLE};
      end
      else if (hit(addr, ADDR_IRQ_STAT))
      begin
        r_d.rdat = 32'(r_q.ist);
      end
      else if (hit(addr, ADDR_IRQ_MASK))
      begin
        r_d.rdat = 32'(r_q.imask);
      end
      else if (hit(addr, ADDR_CRC))
      begin
        // Raw remainder, no inversion on the way out.
        r_d.rdat = r_q.crc;
      end
      else if (hit(addr, ADDR_FIELDS))
      begin
        // The alert limit byte has no place in this word; software sees it through the flags.
        r_d.rdat = {r_q.cw,
                    2'h0,
                    r_q.rwy,
                    6'h0,
                    r_q.cw_qm};
      end
      else
      begin
        r_d.rdat = '0;
      end
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      r_q <= '{st: ST_IDLE, crc: CRC_INIT, default: '0};
    end
    else
    begin
      r_q <= r_d;
    end
  end

  assign rdata = r_q.rdat;
  assign out_valid = r_q.ov;
  assign out_bit = r_q.ob;
  assign busy = r_q.busy;
  assign block_done = r_q.done;
  assign block_ok = r_q.ok;
  assign crc_error = r_q.err;
  assign lateral_only = r_q.lat;
  assign vertical_usable = r_q.vert;
  assign course_width_qm = r_q.cw_qm;
  assign irq = r_q.irq;

endmodule : blk_crc_chk

// ===== rtl/blk_crc_pkg.sv
/*
  Shared constants for the approach data block checker: block layout, field positions,
  generator, register map and interrupt bits.
  Assumes one 200 MHz clock and a plain strobe register port with 32-bit data.
*/
package blk_crc_pkg;

  localparam int CRC_W = 32;
  localparam logic [CRC_W-1:0] CRC_POLY = 32'h814141ab;
  localparam logic [CRC_W-1:0] CRC_INIT = 32'h00000000;

  localparam int CNT_W = 9;
  localparam logic [CNT_W-1:0] MSG_BITS = 9'h120;
  localparam logic [CNT_W-1:0] BLK_BITS = 9'h140;
  localparam logic [CNT_W-1:0] RWY_LSB = 9'h028;
  localparam logic [CNT_W-1:0] RWY_W = 9'h006;
  localparam logic [CNT_W-1:0] CW_LSB = 9'h100;
  localparam logic [CNT_W-1:0] CW_W = 9'h008;
  localparam logic [CNT_W-1:0] VAL_LSB = 9'h118;
  localparam logic [CNT_W-1:0] VAL_W = 9'h008;

  localparam int QM_W = 10;
  localparam logic [QM_W-1:0] CW_BASE_QM = 10'h140;
  localparam logic [QM_W-1:0] CW_HELI_QM = 10'h098;
  localparam logic [5:0] RWY_HELI = 6'h00;
  localparam logic [7:0] VAL_LATERAL = 8'h00;

  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_CRC = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_FIELDS = 8'h14;

  localparam int CTRL_GEN = 0;
  localparam int CTRL_START = 1;
  localparam int IRQ_W = 2;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ERR = 1;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_MSG,
    ST_CHK,
    ST_EMIT
  } state_t;

endpackage : blk_crc_pkg

// ===== rtl/crc_step.sv
/*
  One serial step of the remainder division: takes the remainder and one message bit.
  Purely combinational; the caller holds the remainder register.
*/
`timescale 1ns/10ps
module crc_step
  import blk_crc_pkg::*;
(
  input wire logic [CRC_W-1:0] crc,
  input wire logic bit_in,
  output logic [CRC_W-1:0] crc_next
);

  logic fb;

  // Feeding the bit at the top is the same as appending 32 zeros to the dividend.
  assign fb = crc[CRC_W-1] ^ bit_in;
  // Subtraction is plain exclusive-OR with the generator.
  assign crc_next = {crc[CRC_W-2:0], 1'b0} ^ (fb ? CRC_POLY : CRC_INIT);

endmodule : crc_step

// ===== verification/blk_crc_chk_sva.sv
/*
  Port assertions for the block checker.
  Assumes one clock and an asynchronous active-high reset.
*/
`timescale 1ns/10ps
module blk_crc_chk_sva
  import blk_crc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic block_start,
  input wire logic in_valid,
  input wire logic in_bit,
  input wire logic out_valid,
  input wire logic out_bit,
  input wire logic busy,
  input wire logic block_done,
  input wire logic block_ok,
  input wire logic crc_error,
  input wire logic lateral_only,
  input wire logic vertical_usable,
  input wire logic [QM_W-1:0] course_width_qm
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  // A block restarts on the pin or on a control write with the start bit set.
  logic restart;
  assign restart = block_start || (wr && addr == ADDR_CTRL && wdata[CTRL_START]);
  // Echo is promised for message bits only, so they are counted from each start.
  logic [CNT_W-1:0] taken_q;
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      taken_q <= '0;
    else if (restart)
      taken_q <= '0;
    else if (in_valid && busy && taken_q < MSG_BITS)
      taken_q <= taken_q + 1'b1;
  end
  sequence s_msg_bit;
    in_valid && busy && !restart && taken_q < MSG_BITS;
  endsequence
  chk_echo_bit: assert property (s_msg_bit |=> out_valid && out_bit == $past(in_bit))
    else $error("bit not echoed");
  chk_start_vert: assert property (restart |=> !vertical_usable)
    else $error("vertical usable at start");
  chk_start_clr: assert property (restart |=> !block_done && busy)
    else $error("start did not restart");
  chk_done_busy: assert property ($rose(block_done) |-> $past(busy))
    else $error("done without block");
  chk_ok_err: assert property (block_done |-> block_ok != crc_error)
    else $error("ok and error disagree");
  chk_res_hold: assert property (block_done && !restart |=> $stable({block_ok, crc_error}))
    else $error("result changed");
  chk_vert_lat: assert property (block_done |-> vertical_usable == !lateral_only)
    else $error("vertical flag wrong");
  chk_heli_cw: assert property (block_done |-> course_width_qm == 10'h098 || course_width_qm >= 10'h140)
    else $error("course width wrong");
endmodule : blk_crc_chk_sva
bind blk_crc_chk blk_crc_chk_sva i_blk_crc_chk_sva (
  .clk(clk),
  .reset(reset),
  .addr(addr),
  .wdata(wdata),
  .wr(wr),
  .block_start(block_start),
  .in_valid(in_valid),
  .in_bit(in_bit),
  .out_valid(out_valid),
  .out_bit(out_bit),
  .busy(busy),
  .block_done(block_done),
  .block_ok(block_ok),
  .crc_error(crc_error),
  .lateral_only(lateral_only),
  .vertical_usable(vertical_usable),
  .course_width_qm(course_width_qm)
);

// ===== verification/loader.sv
/*
  Loader model: a start pulse, then one block bit per valid cycle.
  Assumes the design samples on the rising clock edge.
*/
`timescale 1ns/10ps
module loader
(
  input wire logic clk,
  output logic block_start,
  output logic in_valid,
  output logic in_bit
);
  initial
    {block_start, in_valid, in_bit} = 3'b0;
  // In gaps the data line flips, so a stale bit never looks valid.
  task automatic send(logic [319:0] b, int n, bit slow);
    @(posedge clk);
    block_start <= 1'b1;
    @(posedge clk);
    block_start <= 1'b0;
    feed(b, n, slow);
  endtask : send
  // Streams bits only; the caller has already started the block some other way.
  task automatic feed(logic [319:0] b, int n, bit slow);
    for (int i = 0; i < n; i++)
    begin
      if (slow && i[0])
      begin
        {in_valid, in_bit} <= {1'b0, ~in_bit};
        @(posedge clk);
      end
      {in_valid, in_bit} <= {1'b1, b[i]};
      @(posedge clk);
    end
    {in_valid, in_bit} <= {1'b0, ~in_bit};
  endtask : feed
endmodule : loader

// ===== verification/tb_blk_crc_chk.sv
/*
  Self-checking bench: loader model on the stream, strobe tasks on the registers.
  Assumes the loader and checker files compile first.
*/
`timescale 1ns/10ps
module tb_blk_crc_chk
  import blk_crc_pkg::*;
;
  logic clk, reset, wr, rd, block_start, in_valid, in_bit, out_valid, out_bit, busy, irq;
  logic block_done, block_ok, crc_error, lateral_only, vertical_usable;
  logic [ADDR_W-1:0] addr;
  logic [31:0] wdata, rdata, v, r;
  logic [QM_W-1:0] course_width_qm;
  logic [319:0] b;
  logic q[$];
  int err_count, total_checks;
  blk_crc_chk i_blk_crc_chk (
    .clk(clk),
    .reset(reset),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .rd(rd),
    .rdata(rdata),
    .block_start(block_start),
    .in_valid(in_valid),
    .in_bit(in_bit),
    .out_valid(out_valid),
    .out_bit(out_bit),
    .busy(busy),
    .block_done(block_done),
    .block_ok(block_ok),
    .crc_error(crc_error),
    .lateral_only(lateral_only),
    .vertical_usable(vertical_usable),
    .course_width_qm(course_width_qm),
    .irq(irq)
  );
  loader i_loader (
    .clk(clk),
    .block_start(block_start),
    .in_valid(in_valid),
    .in_bit(in_bit)
  );
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(negedge clk)
    if (out_valid === 1'b1)
      q.push_back(out_bit);
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    total_checks++;
    if (s !== e)
    begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic wr_reg(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    {wr, addr, wdata} <= {1'b1, a, d};
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(logic [7:0] a);
    @(posedge clk);
    {rd, addr} <= {1'b1, a};
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask : rd_reg
  task automatic mk(logic [5:0] rw, logic [7:0] cw, logic [7:0] vl);
    b = {10{32'h5a3c96e1}};
    {b[287:280], b[263:256], b[45:40]} = {vl, cw, rw};
    r = 32'h0;
    for (int i = 0; i < 288; i++)
      r = {r[30:0], 1'b0} ^ (r[31] ^ b[i] ? 32'h814141ab : 32'h0);
    for (int k = 0; k < 32; k++)
      b[288+k] = r[31-k];
  endtask : mk
  task automatic fin(string n, logic ok, logic [QM_W-1:0] cw, logic lat);
    for (int i = 0; i < 60 && block_done !== 1'b1; i++)
      @(negedge clk);
    @(negedge clk);
    chk(n, {block_done, block_ok, crc_error, lateral_only, vertical_usable, course_width_qm},
      {1'b1, ok, !ok, lat, !lat, cw});
  endtask : fin
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results
  initial
  begin
    {reset, wr, rd, addr, wdata} = {1'b1, 42'h0};
    {err_count, total_checks} = 64'h0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    wr_reg(ADDR_IRQ_MASK, 32'h3);
    mk(6'h00, 8'h2a, 8'h00);
    i_loader.send(b, 100, 1'b0);
    i_loader.send(b, 320, 1'b0);
    fin("heli", 1'b1, 10'h098, 1'b1);
    rd_reg(ADDR_IRQ_STAT);
    chk("irq_done", {irq, v[1:0]}, 3'b101);
    wr_reg(ADDR_IRQ_STAT, 32'h1);
    wr_reg(ADDR_IRQ_MASK, 32'h0);
    mk(6'h07, 8'h10, 8'h05);
    b[300] = ~b[300];
    i_loader.send(b, 320, 1'b1);
    fin("bad", 1'b0, 10'h150, 1'b0);
    rd_reg(ADDR_IRQ_STAT);
    chk("irq_mask", {irq, v[1:0]}, 3'b011);
    rd_reg(ADDR_STATUS);
    chk("status", v[5:0], 6'b101010);
    wr_reg(ADDR_IRQ_MASK, 32'h2);
    rd_reg(8'h3c);
    chk("unmapped", {irq, v[30:0]}, {1'b1, 31'h0});
    wr_reg(ADDR_IRQ_STAT, 32'h3);
    rd_reg(ADDR_IRQ_STAT);
    chk("irq_clr", {irq, v[1:0]}, 3'b000);
    wr_reg(ADDR_CTRL, 32'h1);
    mk(6'h24, 8'hff, 8'hff);
    q.delete();
    i_loader.send(b, 288, 1'b0);
    fin("gen", 1'b1, 10'h23f, 1'b0);
    chk("gen_len", q.size(), 320);
    for (int i = 0; i < 320; i++)
      chk("gen_bit", q[i], b[i]);
    rd_reg(ADDR_CRC);
    chk("crc_reg", v, r);
    rd_reg(ADDR_FIELDS);
    chk("fields", v, {8'hff, 2'h0, 6'h24, 6'h0, 10'h23f});
    rd_reg(ADDR_CTRL);
    chk("ctrl", v, 32'h1);
    wr_reg(ADDR_CTRL, 32'h2);
    i_loader.feed(b, 320, 1'b0);
    fin("sw_start", 1'b1, 10'h23f, 1'b0);
    results();
  end
  initial
  begin
    #100000;
    err_count++;
    results();
  end
endmodule : tb_blk_crc_chk
